// >>> bench/usc_peer.sv
// Purpose: Far-end serial peer that decodes sent frames and sends frames in.
// Assumes: One bit lasts 320 system clocks; framing settings come from the bench.
// Notes: Frames to send are 14-bit patterns, LSB first, padded with idle ones.
`timescale 1ns/1ps
module usc_peer (
    input wire logic clock, // System clock.
    input wire logic serialOutLine, // Line driven by the block.
    input wire logic [1:0] parMode, // Parity mode in use.
    input wire logic char8, // High for eight data bits.
    output logic serialInLine, // Line into the block, idle high.
    output logic [8:0] gotWord, // Parity bit and data of the last frame.
    output logic gotPulse // One cycle when a frame was decoded.
);
    localparam int BIT_CLKS = 320;
    int k;
    // Sampling mid-bit keeps the peer tolerant of the launch delay.
    initial begin
        gotWord = 9'h000;
        gotPulse = 1'b0;
        forever begin
            @(negedge serialOutLine);
            repeat (BIT_CLKS / 2) @(posedge clock);
            gotWord <= 9'h000;
            for (k = 0; k < (char8 ? 8 : 7); k++) begin
                repeat (BIT_CLKS) @(posedge clock);
                gotWord[k] <= serialOutLine;
            end
            if (parMode != 2'h0) begin
                repeat (BIT_CLKS) @(posedge clock);
                gotWord[8] <= serialOutLine;
            end
            gotPulse <= 1'b1;
            @(posedge clock);
            gotPulse <= 1'b0;
        end
    end
    // The line rests high between frames, as an idle sender holds it.
    initial serialInLine = 1'b1;
    task automatic send(input logic [13:0] frame);
        for (int b = 0; b < 14; b++) begin
            serialInLine <= frame[b];
            repeat (BIT_CLKS) @(posedge clock);
        end
    endtask : send
endmodule : usc_peer

// >>> bench/usc_top_bench.sv
// Purpose: Self-checking bench for the serial port control and status block.
// Assumes: 40 MHz clock; register port strobes last one cycle.
// Notes: Reads and frames are checked from queues by a monitor; the peer decodes and sends frames but checks nothing.
`timescale 1ns/1ps
module usc_top_bench;
    import usc_pkg::*;
    logic clock, rstn, regWr, regRd, serialInLine, serialOutLine, rdSeen, char8;
    logic transmitDoneIrq, receiveDoneIrq, receiveErrIrq, gotPulse;
    logic [15:0] regAddr;
    logic [7:0] regWrData, regRdData, m, d;
    logic [1:0] parMode;
    logic [8:0] gotWord;
    logic [31:0] rng;
    logic [23:0] rdQ[$];
    logic [8:0] txQ[$];
    int error_cnt, num_checks, txDone, rxDone, rxErr, n, i, bits;
    usc_top usc_top_inst (.clock(clock), .rstn(rstn), .regAddr(regAddr), .regWr(regWr),
        .regRd(regRd), .regWrData(regWrData), .regRdData(regRdData),
        .serialInLine(serialInLine), .serialOutLine(serialOutLine),
        .transmitDoneIrq(transmitDoneIrq), .receiveDoneIrq(receiveDoneIrq),
        .receiveErrIrq(receiveErrIrq));
    usc_peer usc_peer_inst (.clock(clock), .serialOutLine(serialOutLine), .parMode(parMode),
        .char8(char8), .serialInLine(serialInLine), .gotWord(gotWord), .gotPulse(gotPulse));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Read data stands from the edge after the strobe, so it is judged one edge later.
    always @(posedge clock) begin
        rdSeen <= (regRd === 1'b1);
        txDone <= txDone + (transmitDoneIrq === 1'b1);
        rxErr <= rxErr + (receiveErrIrq === 1'b1);
        rxDone <= rxDone + (receiveDoneIrq === 1'b1);
        if (rdSeen && rdQ.size() > 0) begin
            check($sformatf("read %h", rdQ[0][23:8]), {1'b0, rdQ[0][7:0]}, {1'b0, regRdData});
            void'(rdQ.pop_front());
        end
        if (gotPulse === 1'b1 && txQ.size() > 0) begin
            check("frame on line", txQ[0], gotWord);
            void'(txQ.pop_front());
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    function automatic logic par(input logic [7:0] v, input logic [1:0] p);
        return (p == 2'h2) ? ~^v : ((p == 2'h3) ? ^v : 1'b0);
    endfunction : par
    // Builds start, data, optional parity and one stop bit; the rest stays idle.
    function automatic logic [13:0] frame(input logic [7:0] v, input logic [1:0] p,
        input logic c8, input logic badP, input logic badS);
        logic [13:0] f;
        int x;
        f = 14'h3FFE;
        for (x = 0; x < 8; x++) if (x < 7 || c8) f[x + 1] = v[x];
        x = c8 ? 9 : 8;
        if (p != 2'h0) begin
            f[x] = par(c8 ? v : v & 8'h7F, p) ^ badP;
            x++;
        end
        f[x] = ~badS;
        return f;
    endfunction : frame
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clock);
        regAddr <= a;
        regWrData <= v;
        regWr <= 1'b1;
        @(posedge clock);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] v);
        rdQ.push_back({a, v});
        @(posedge clock);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clock);
        regRd <= 1'b0;
    endtask : rd
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    // The run needs about 68500 cycles; the limit leaves some margin.
    initial begin
        #(95000 * 25);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        {rstn, regWr, regRd, rdSeen, parMode, regAddr, regWrData} = '0;
        {char8, error_cnt, num_checks, txDone, rxDone, rxErr, rng} = {1'b1, 160'd0, 32'd60755};
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        rd(ADDR_MODE, MODE_RESET);
        rd(ADDR_STATUS, STAT_RESET);
        rd(ADDR_TXDATA, READ_ZERO);
        rd(16'h1234, READ_ZERO);
        for (i = 0; i < 4; i++) begin
            parMode <= i[1:0];
            char8 <= ~i[0];
            // Enables drop first so the framing fields change only while both are off.
            if (i > 0) wr(ADDR_MODE, m & 8'h9F);
            m = {3'h7, i[1:0], ~i[0], i[0], 1'b1};
            wr(ADDR_MODE, m & 8'h9F);
            repeat (10) @(posedge clock);
            wr(ADDR_MODE, m);
            rd(ADDR_MODE, m);
            repeat (30) @(posedge clock);
            rng = xs(rng);
            d = char8 ? rng[7:0] : rng[7:0] & MASK_7BIT;
            txQ.push_back({par(d, parMode), d});
            wr(ADDR_TXDATA, rng[7:0]);
            n = 0;
            while (transmitDoneIrq !== 1'b1 && n < 5000) begin
                @(posedge clock);
                n++;
            end
            bits = 320 * (2 + (char8 ? 8 : 7) + (parMode != 2'h0) + i % 2);
            check("frame length", 9'h001, {8'h00, n >= bits - 2 && n <= bits + 60});
            usc_peer_inst.send(frame(rng[7:0], parMode, char8, 1'b0, 1'b0));
            rd(ADDR_STATUS, STAT_RESET);
            rd(ADDR_RXBUF, d);
            usc_peer_inst.send(frame(rng[15:8], parMode, char8, i > 0, i == 0));
            rd(ADDR_STATUS, (i == 0) ? 8'h02 : ((i == 1) ? 8'h00 : 8'h04));
            rd(ADDR_STATUS, STAT_RESET);
            rd(ADDR_RXBUF, char8 ? rng[15:8] : rng[15:8] & MASK_7BIT);
        end
        rng = xs(rng);
        usc_peer_inst.send(frame(rng[7:0], parMode, char8, 1'b0, 1'b0));
        usc_peer_inst.send(frame(rng[15:8], parMode, char8, 1'b0, 1'b0));
        rd(ADDR_STATUS, 8'h01);
        rd(ADDR_RXBUF, rng[7:0] & MASK_7BIT);
        usc_peer_inst.send(frame(rng[23:16], parMode, char8, 1'b1, 1'b0));
        wr(ADDR_MODE, m & 8'hDF);
        repeat (10) @(posedge clock);
        rd(ADDR_STATUS, STAT_RESET);
        wr(ADDR_TXDATA, 8'h00);
        repeat (1000) @(posedge clock);
        wr(ADDR_MODE, m & 8'h9F);
        repeat (20) @(posedge clock);
        check("line after abort", 9'h001, {8'h00, serialOutLine});
        wr(ADDR_TXDATA, 8'h00);
        wr(ADDR_MODE, m & 8'hDF);
        repeat (4000) @(posedge clock);
        check("frames after disable", 9'h004, txDone[8:0]);
        check("error events", 9'h005, rxErr[8:0]);
        check("bytes stored", 9'h00A, rxDone[8:0]);
        wr(ADDR_MODE, m & 8'h9F);
        wr(ADDR_MODE, MODE_RESET);
        rd(ADDR_RXBUF, DATA_IDLE);
        rd(ADDR_STATUS, STAT_RESET);
        repeat (3) @(posedge clock);
        // Every noted frame and read must have been matched by an observed result.
        check("notes left", 9'h000, 9'(txQ.size() + rdQ.size()));
        report_and_stop();
    end
endmodule : usc_top_bench

// >>> hdl/usc_rate_div.sv
// Purpose: Base clock and oversample enables for the serial port.
// Assumes: One clock; run low holds the base clock still.
// Notes: Outputs are one-cycle enables, never clocks.
`timescale 1ns/1ps
module usc_rate_div (
    input wire logic clock, // System clock.
    input wire logic rstn, // Asynchronous reset, active low.
    input wire logic run, // Power enable; low stops both enables.
    output logic baseTick, // One pulse per base clock period.
    output logic sampleTick // One pulse per oversample period.
);
    import usc_pkg::*;

    logic [3:0] baseCnt_q;
    logic [3:0] sampleCnt_q;

    // Base divider; held at zero while powered down so the base clock stays low.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            baseCnt_q <= 4'h0;
            baseTick <= 1'b0;
        end else if (!run) begin
            baseCnt_q <= 4'h0;
            baseTick <= 1'b0;
        end else if (baseCnt_q == BASE_DIV - 4'h1) begin
            baseCnt_q <= 4'h0;
            baseTick <= 1'b1;
        end else begin
            baseCnt_q <= baseCnt_q + 4'h1;
            baseTick <= 1'b0;
        end
    end

    // Oversample divider counts base ticks.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sampleCnt_q <= 4'h0;
            sampleTick <= 1'b0;
        end else if (!run) begin
            sampleCnt_q <= 4'h0;
            sampleTick <= 1'b0;
        end else if (baseTick && sampleCnt_q == SAMPLE_DIV - 4'h1) begin
            sampleCnt_q <= 4'h0;
            sampleTick <= 1'b1;
        end else begin
            if (baseTick) begin
                sampleCnt_q <= sampleCnt_q + 4'h1;
            end
            sampleTick <= 1'b0;
        end
    end
endmodule : usc_rate_div

// >>> hdl/usc_top.sv
// Purpose: Serial port mode control, transmit data register and receive error status.
// Assumes: Register port strobes are one-cycle pulses on the system clock.
// Notes: Power-down clears the internal circuit on the next clock edge.
`timescale 1ns/1ps
module usc_top (
    input wire logic clock, // System clock, 40 MHz.
    input wire logic rstn, // Asynchronous reset, active low.
    input wire logic [15:0] regAddr, // Register address.
    input wire logic regWr, // Write strobe, one cycle.
    input wire logic regRd, // Read strobe, one cycle.
    input wire logic [7:0] regWrData, // Write data.
    output logic [7:0] regRdData, // Read data, valid the cycle after regRd.
    input wire logic serialInLine, // Receive pin.
    output logic serialOutLine, // Transmit pin.
    output logic transmitDoneIrq, // Pulse when a frame has been sent.
    output logic receiveDoneIrq, // Pulse when a byte lands in the buffer.
    output logic receiveErrIrq // Pulse when a reception ends in error.
);
    import usc_pkg::*;

    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} usc_tx_t;
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} usc_rx_t;

    logic [7:0] mode_q;
    logic [7:0] status_q;
    logic [7:0] txData_q;
    logic txPending_q;
    logic [7:0] rxBuf_q;
    logic rxFull_q;
    logic txEnSync_q;
    logic rxEnSync_q;
    logic [2:0] rxSync_q;
    logic rxLevel_q;
    logic baseTick;
    logic sampleTick;
    usc_tx_t txState_q;
    logic [3:0] txCnt_q;
    logic [2:0] txBit_q;
    logic [7:0] txShift_q;
    logic txPar_q;
    logic txSecondStop_q;
    usc_rx_t rxState_q;
    logic [3:0] rxCnt_q;
    logic [2:0] rxBit_q;
    logic [7:0] rxShift_q;
    logic rxParBit_q;

    wire power = mode_q[MODE_POWER];
    wire txEnBit = mode_q[MODE_TXEN];
    wire rxEnBit = mode_q[MODE_RXEN];
    wire char8 = mode_q[MODE_CHAR8];
    wire stop2 = mode_q[MODE_STOP2];
    wire [1:0] parMode = {mode_q[MODE_PAR_HI], mode_q[MODE_PAR_LO]};
    wire [2:0] lastBit = char8 ? LAST_BIT8 : LAST_BIT7;
    wire wrMode = regWr && regAddr == ADDR_MODE;
    wire wrTxData = regWr && regAddr == ADDR_TXDATA;
    wire rdStatus = regRd && regAddr == ADDR_STATUS;
    wire rdRxBuf = regRd && regAddr == ADDR_RXBUF;
    wire txRun = power && txEnSync_q;
    wire rxRun = power && rxEnSync_q;
    wire txLaunch = txRun && sampleTick && txState_q == TX_IDLE && txPending_q;
    wire bitEnd = sampleTick && rxCnt_q == OVS_LAST;
    wire rxFinish = rxRun && rxState_q == RX_STOP && bitEnd;
    // Seven-bit characters arrive shifted one place too high; realign with MSB zero.
    wire [7:0] rxWord = char8 ? rxShift_q : {1'b0, rxShift_q[7:1]};
    wire expectOdd = parMode == PAR_ODD;
    wire checkPar = parMode == PAR_ODD || parMode == PAR_EVEN;
    wire parErr = checkPar && ((^rxWord ^ rxParBit_q) != expectOdd);
    wire frameErr = !rxLevel_q;
    wire overrun = rxFull_q;
    wire [7:0] statSet = rxFinish ?
        {5'h00, parErr, frameErr, overrun} : STAT_RESET;

    usc_rate_div usc_rate_div_inst (
        .clock(clock),
        .rstn(rstn),
        .run(power),
        .baseTick(baseTick),
        .sampleTick(sampleTick)
    );

    // Mode register; every field is software owned.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mode_q <= MODE_RESET;
        end else if (wrMode) begin
            mode_q <= regWrData;
        end
    end

    // Direction enables follow the register on base clock edges and clear on the next clock edge at power-down.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            txEnSync_q <= 1'b0;
            rxEnSync_q <= 1'b0;
        end else if (!power) begin
            txEnSync_q <= 1'b0;
            rxEnSync_q <= 1'b0;
        end else if (baseTick) begin
            txEnSync_q <= txEnBit;
            rxEnSync_q <= rxEnBit;
        end
    end

    // Three-stage input sampler; a level is accepted once stages two and three agree.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rxSync_q <= 3'h7;
            rxLevel_q <= 1'b1;
        end else begin
            rxSync_q <= {rxSync_q[1:0], serialInLine};
            if (!power) begin
                rxLevel_q <= 1'b1;
            end else if (rxSync_q[1] == rxSync_q[2]) begin
                rxLevel_q <= rxSync_q[2];
            end
        end
    end

    // Transmit data register; a write while a byte waits or shifts is ignored.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            txData_q <= DATA_IDLE;
            txPending_q <= 1'b0;
        end else if (!power || !txEnBit) begin
            txData_q <= DATA_IDLE;
            txPending_q <= 1'b0;
        end else if (wrTxData && !txPending_q && txState_q == TX_IDLE) begin
            txData_q <= regWrData;
            txPending_q <= 1'b1;
        end else if (txLaunch) begin
            txPending_q <= 1'b0;
        end
    end

    // Transmit sequencer; each bit lasts sixteen oversample periods.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            txState_q <= TX_IDLE;
            txCnt_q <= 4'h0;
            txBit_q <= 3'h0;
            txShift_q <= DATA_IDLE;
            txPar_q <= 1'b0;
            txSecondStop_q <= 1'b0;
            serialOutLine <= 1'b1;
            transmitDoneIrq <= 1'b0;
        end else if (!txRun) begin
            txState_q <= TX_IDLE;
            txCnt_q <= 4'h0;
            txBit_q <= 3'h0;
            serialOutLine <= 1'b1;
            transmitDoneIrq <= 1'b0;
        end else begin
            transmitDoneIrq <= 1'b0;
            if (txLaunch) begin
                txState_q <= TX_START;
                txCnt_q <= 4'h0;
                txShift_q <= txData_q;
                txPar_q <= (parMode == PAR_ZERO) ? 1'b0 :
                    ((^(txData_q & (char8 ? DATA_IDLE : MASK_7BIT))) ^
                    (parMode == PAR_ODD));
                serialOutLine <= 1'b0;
            end else if (sampleTick && txState_q != TX_IDLE) begin
                txCnt_q <= txCnt_q + 4'h1;
                if (txCnt_q == OVS_LAST) begin
                    case (txState_q)
                        TX_START: begin
                            txState_q <= TX_DATA;
                            txBit_q <= 3'h0;
                            serialOutLine <= txShift_q[0];
                        end
                        TX_DATA: begin
                            txShift_q <= {1'b1, txShift_q[7:1]};
                            txBit_q <= txBit_q + 3'h1;
                            if (txBit_q != lastBit) begin
                                serialOutLine <= txShift_q[1];
                            end else if (parMode != PAR_NONE) begin
                                txState_q <= TX_PAR;
                                serialOutLine <= txPar_q;
                            end else begin
                                txState_q <= TX_STOP;
                                txSecondStop_q <= 1'b0;
                                serialOutLine <= 1'b1;
                            end
                        end
                        TX_PAR: begin
                            txState_q <= TX_STOP;
                            txSecondStop_q <= 1'b0;
                            serialOutLine <= 1'b1;
                        end
                        TX_STOP: begin
                            if (stop2 && !txSecondStop_q) begin
                                txSecondStop_q <= 1'b1;
                            end else begin
                                txState_q <= TX_IDLE;
                                transmitDoneIrq <= 1'b1;
                            end
                        end
                        default: begin
                            txState_q <= TX_IDLE;
                        end
                    endcase
                end
            end
        end
    end

    // Receive sequencer; start bit checked mid-bit, later bits one period apart.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rxState_q <= RX_IDLE;
            rxCnt_q <= 4'h0;
            rxBit_q <= 3'h0;
            rxShift_q <= READ_ZERO;
            rxParBit_q <= 1'b0;
        end else if (!rxRun) begin
            rxState_q <= RX_IDLE;
            rxCnt_q <= 4'h0;
            rxBit_q <= 3'h0;
        end else if (sampleTick) begin
            rxCnt_q <= rxCnt_q + 4'h1;
            case (rxState_q)
                RX_IDLE: begin
                    rxCnt_q <= 4'h0;
                    if (!rxLevel_q) begin
                        rxState_q <= RX_START;
                    end
                end
                RX_START: begin
                    if (rxCnt_q == OVS_MID) begin
                        rxCnt_q <= 4'h0;
                        rxBit_q <= 3'h0;
                        rxState_q <= rxLevel_q ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rxCnt_q == OVS_LAST) begin
                        rxShift_q <= {rxLevel_q, rxShift_q[7:1]};
                        rxBit_q <= rxBit_q + 3'h1;
                        if (rxBit_q == lastBit) begin
                            rxState_q <= (parMode != PAR_NONE) ? RX_PAR : RX_STOP;
                        end
                    end
                end
                RX_PAR: begin
                    if (rxCnt_q == OVS_LAST) begin
                        rxParBit_q <= rxLevel_q;
                        rxState_q <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    // Only one stop bit is sampled whatever the transmit setting.
                    if (rxCnt_q == OVS_LAST) begin
                        rxState_q <= RX_IDLE;
                    end
                end
                default: begin
                    rxState_q <= RX_IDLE;
                end
            endcase
        end
    end

    // Receive buffer; an unread byte is kept and the new one dropped.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rxBuf_q <= DATA_IDLE;
            rxFull_q <= 1'b0;
            receiveDoneIrq <= 1'b0;
        end else if (!power) begin
            rxBuf_q <= DATA_IDLE;
            rxFull_q <= 1'b0;
            receiveDoneIrq <= 1'b0;
        end else begin
            receiveDoneIrq <= rxFinish && !rxFull_q;
            if (rxFinish && !rxFull_q) begin
                rxBuf_q <= rxWord;
                rxFull_q <= 1'b1;
            end else if (rdRxBuf) begin
                rxFull_q <= 1'b0;
            end
        end
    end

    // Error flags; a new error in the reading cycle survives the clear.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            status_q <= STAT_RESET;
            receiveErrIrq <= 1'b0;
        end else if (!power || !rxEnBit) begin
            status_q <= STAT_RESET;
            receiveErrIrq <= 1'b0;
        end else begin
            status_q <= (rdStatus ? STAT_RESET : status_q) | statSet;
            receiveErrIrq <= |statSet;
        end
    end

    // Read mux; transmit data and unmapped addresses read as zero.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            regRdData <= READ_ZERO;
        end else if (regRd) begin
            if (regAddr == ADDR_MODE) begin
                regRdData <= mode_q;
            end else if (regAddr == ADDR_STATUS) begin
                regRdData <= status_q;
            end else if (regAddr == ADDR_RXBUF) begin
                regRdData <= rxBuf_q;
            end else begin
                regRdData <= READ_ZERO;
            end
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    txdata_forced_a: assert property ((!power || !txEnBit) |=> txData_q == DATA_IDLE)
        else $error("Transmit data not forced to idle value.");
    tx_start_a: assert property (txLaunch |=> !serialOutLine && txState_q == TX_START)
        else $error("Launch did not drive a start bit.");
    txread_zero_a: assert property (regRd && regAddr == ADDR_TXDATA |=> regRdData == READ_ZERO)
        else $error("Transmit data read back.");
    power_clear_a: assert property (!power |=> rxBuf_q == DATA_IDLE && !txEnSync_q
        && serialOutLine)
        else $error("Power-down did not clear the circuit.");
    status_clear_a: assert property ((!power || !rxEnBit) |=> status_q == STAT_RESET)
        else $error("Status not cleared on disable.");
    read_clear_a: assert property (rdStatus && !rxFinish && power && rxEnBit
        |=> status_q == STAT_RESET)
        else $error("Status read did not clear flags.");
    zero_parity_a: assert property (parMode == PAR_ZERO && rxFinish && $stable(mode_q)
        && !rdStatus |=> status_q[STAT_PARITY] == $past(status_q[STAT_PARITY]))
        else $error("Parity flag set in zero parity mode.");
    overrun_keep_a: assert property (rxFinish && rxFull_q && power && rxEnBit
        |=> status_q[STAT_OVERRUN] && $stable(rxBuf_q))
        else $error("Overrun not flagged or byte not discarded.");
    msb_zero_a: assert property (rxFinish && !rxFull_q && !char8 && power
        |=> rxBuf_q[7] == 1'b0)
        else $error("Seven-bit character has MSB set.");
    frame_err_a: assert property (rxFinish && !rxLevel_q && power && rxEnBit
        |=> status_q[STAT_FRAME])
        else $error("Missing stop bit not flagged.");
    done_line_a: assert property (transmitDoneIrq |-> serialOutLine && txState_q == TX_IDLE)
        else $error("Done pulse while line not at stop level.");
endmodule : usc_top

// >>> include/usc_pkg.sv
// Purpose: Shared constants for the serial port control and status block.
// Assumes: One 40 MHz clock; register port with byte-wide data.
// Notes: Offsets, field positions, reset values and rate counts live here only.
package usc_pkg;
    // Register addresses on the peripheral register port.
    localparam logic [15:0] ADDR_MODE = 16'hFF50;
    localparam logic [15:0] ADDR_RXBUF = 16'hFF52;
    localparam logic [15:0] ADDR_STATUS = 16'hFF53;
    localparam logic [15:0] ADDR_TXDATA = 16'hFF55;
    // Mode register field positions.
    localparam int MODE_POWER = 7;
    localparam int MODE_TXEN = 6;
    localparam int MODE_RXEN = 5;
    localparam int MODE_PAR_HI = 4;
    localparam int MODE_PAR_LO = 3;
    localparam int MODE_CHAR8 = 2;
    localparam int MODE_STOP2 = 1;
    // Status register field positions.
    localparam int STAT_PARITY = 2;
    localparam int STAT_FRAME = 1;
    localparam int STAT_OVERRUN = 0;
    // Reset values and the seven-bit data mask.
    localparam logic [7:0] MODE_RESET = 8'h01;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [7:0] DATA_IDLE = 8'hFF;
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam logic [7:0] MASK_7BIT = 8'h7F;
    // Parity modes.
    typedef enum logic [1:0] {
        PAR_NONE = 2'h0,
        PAR_ZERO = 2'h1,
        PAR_ODD = 2'h2,
        PAR_EVEN = 2'h3
    } usc_parity_t;
    // Rates: base clock is the system clock divided by BASE_DIV, a sample tick
    // comes every SAMPLE_DIV base ticks, and one bit spans OVS sample ticks.
    localparam logic [3:0] BASE_DIV = 4'h4;
    localparam logic [3:0] SAMPLE_DIV = 4'h5;
    localparam logic [3:0] OVS_LAST = 4'hF;
    localparam logic [3:0] OVS_MID = 4'h7;
    // Data bit indices of the last bit for each character length.
    localparam logic [2:0] LAST_BIT8 = 3'h7;
    localparam logic [2:0] LAST_BIT7 = 3'h6;
endpackage : usc_pkg
